// >>> verilog/ccc_pkg.sv
// ccc_pkg: constants and carrier types for the charge cycle controller
// assumes a 200 MHz system clock and an apb register port
package ccc_pkg;
    // ****************************************
    // clock and time
    // ****************************************
    localparam int CLK_HZ        = 200_000_000;
    localparam int ALERT_US      = 256;
    localparam int ALERT_CYC     = ALERT_US * (CLK_HZ / 1_000_000);
    localparam int HALF_SEC_CYC  = CLK_HZ / 2;
    localparam int SAFE_SHORT_H  = 2;
    localparam int SAFE_FAST_H   = 10;
    localparam int SAFE_SLOW_H   = 20;
    localparam int TOPOFF_STEP_M = 15;
    localparam logic [16:0] LIM_PRE  = 17'(SAFE_SHORT_H * 3600);
    localparam logic [16:0] LIM_FAST = 17'(SAFE_FAST_H * 3600);
    localparam logic [16:0] LIM_SLOW = 17'(SAFE_SLOW_H * 3600);
    localparam logic [16:0] TOPO_STEP = 17'(TOPOFF_STEP_M * 60);

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CURR = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [31:0] CTRL_RST = 32'h0000_b463;
    localparam logic [31:0] CURR_RST = 32'h0046_2211;
    // ctrl fields
    localparam int B_EN     = 0;
    localparam int B_TERM   = 1;
    localparam int B_BYPASS = 2;
    localparam int B_BSWOFF = 3;
    localparam int B_RECHG  = 4;
    localparam int B_TMR    = 5;
    localparam int B_SLOW   = 6;
    localparam int B_TSEL   = 7;
    localparam int F_TOPO   = 8;
    localparam int F_COOL   = 10;
    localparam int F_WARM   = 12;
    localparam int B_WVSEL  = 14;
    localparam int B_PROF   = 15;
    // curr fields
    localparam int F_FAST_CHARGE_CURRENT_SETTING   = 0;
    localparam int F_IPRE   = 8;
    localparam int F_ITERM  = 12;
    localparam int F_VREG   = 16;
    // status codes
    localparam logic [1:0] CS_OFF  = 2'h0;
    localparam logic [1:0] CS_PRE  = 2'h1;
    localparam logic [1:0] CS_FAST = 2'h2;
    localparam logic [1:0] CS_DONE = 2'h3;
    localparam logic [1:0] CF_TMR  = 2'h3;
    localparam logic [2:0] TF_COLD = 3'h5;
    localparam logic [2:0] TF_HOT  = 3'h6;
    localparam logic [2:0] SRC_BST = 3'h7;
    localparam logic [1:0] SCALE_FULL = 2'h3;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_SHORT = 3'b001,
        ST_PRE   = 3'b010,
        ST_FAST  = 3'b011,
        ST_DONE  = 3'b100,
        ST_FAULT = 3'b101
    } ccc_state_e;

    // analog comparator and loop flags
    typedef struct packed {
        logic conv_run;
        logic bat_short;
        logic bat_low;
        logic above_rechg;
        logic below_term;
        logic loops;
        logic battery_fault;
        logic supplement;
    } ccc_ana_s;

    // thermistor zone flags
    typedef struct packed {
        logic cold;
        logic cool;
        logic warm;
        logic hot;
        logic bst_ok;
    } ccc_ts_s;
endpackage : ccc_pkg

// >>> verilog/ccc_tick.sv
// ccc_tick: half-second and one-second enable pulses
// assumes one free-running clock
`timescale 1ns/1ps
module ccc_tick #(
    parameter int HALF_CYC = 100_000_000
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // enables
    output logic      half_tick,
    output logic      sec_tick
);
    logic [31:0] cnt;
    logic        ph;

    // half-second divider
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt       <= 32'h0;
            half_tick <= 1'b0;
        end else if (cnt == 32'(HALF_CYC - 1)) begin
            cnt       <= 32'h0;
            half_tick <= 1'b1;
        end else begin
            cnt       <= cnt + 32'h1;
            half_tick <= 1'b0;
        end
    end

    // every second half tick
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ph       <= 1'b0;
            sec_tick <= 1'b0;
        end else begin
            if (half_tick) ph <= ~ph;
            sec_tick <= half_tick & ph;
        end
    end
endmodule : ccc_tick

// >>> verilog/ccc_ctrl.sv
// ccc_ctrl: charge cycle sequencing, safety and top-off timers, apb regs
// assumes analog flags synchronous to clk_sys; enable pin is asynchronous
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
// Operation
// - enabled device charges autonomously
// - documented charging defaults after reset
// - start only when all conditions hold
// - terminate on low current, high voltage
// - auto recharge below recharge threshold
// - enable toggle or replug restarts cycle
// - phase status codes, alert on completion
// - phase chosen from battery voltage
// - done opens switch, status high
// - termination current field, termination disable
// - top-off follows safety timer, flag
// - top-off setting sampled at termination
// - alert at top-off start and expiry
// - thermistor window gates charging
// - cool zone current scaling
// - warm zone voltage, scale, no termination
// - bypass ignores thermistor, code 000
// - boost suspended outside boost limits
// - safety time 2, 10 or 20 hours
// - timer expiry fault, blink, alert
// - half rate timer under regulation
// - timer freezes on faults, resets on restart
module ccc_ctrl #(
    parameter int ALERT_CYCLES = ccc_pkg::ALERT_CYC,
    parameter int HALF_CYCLES  = ccc_pkg::HALF_SEC_CYC
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // analog side
    input  wire ccc_pkg::ccc_ana_s ana,
    input  wire ccc_pkg::ccc_ts_s  ts,
    input  wire logic [2:0]       src_type,
    input  wire logic             boost_mode,
    input  wire logic             charge_enable_n,
    // controls to power stage
    output logic      [1:0]       i_mode,
    output logic      [1:0]       i_scale,
    output logic                  v_warm_reduce,
    output logic                  batt_switch_on,
    output logic                  boost_suspend,
    output logic      [5:0]       fast_charge_current_setting_code,
    output logic      [3:0]       ipre_code,
    output logic      [3:0]       iterm_code,
    output logic      [7:0]       vreg_code,
    output logic                  recharge_offset_select,
    // status pin and host alert
    output logic                  stat_oe,
    output logic                  alert_n
);
    import ccc_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    ccc_state_e  state;
    logic [31:0] ctrl;
    logic [31:0] curr;
    logic        ce_m, ce_s, en_q;
    logic        half_tick, sec_tick;
    logic [16:0] safe_cnt, topo_cnt, topo_lim;
    logic        safe_ph, topo_ph, topo_run, tfault;
    logic [31:0] alert_cnt;
    logic        blink;
    logic        enable, ts_out, ts_ok, susp, start_ok, charging;
    logic        slow, tick_ok, term_hit, expire, boost_flt;
    logic [16:0] safe_lim;
    logic [1:0]  phase_code;
    logic [2:0]  ts_code;

    // voltage to phase
    function automatic ccc_state_e phase_of(input logic sh, input logic lo);
        phase_of = sh ? ST_SHORT : (lo ? ST_PRE : ST_FAST);
    endfunction : phase_of

    ccc_tick #(.HALF_CYC(HALF_CYCLES)) u_tick (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .half_tick (half_tick),
        .sec_tick  (sec_tick)
    );

    // ****************************************
    // enable pin synchroniser
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ce_m <= 1'b1;
            ce_s <= 1'b1;
            en_q <= 1'b0;
        end else begin
            ce_m <= charge_enable_n;
            ce_s <= ce_m;
            en_q <= enable;
        end
    end

    // ****************************************
    // qualification terms
    // ****************************************
    // enable from bit and pin
    assign enable   = ctrl[B_EN] & ~ce_s;
    assign ts_out   = ts.cold | ts.hot;
    assign ts_ok    = ctrl[B_BYPASS] | ~ts_out;
    assign susp     = ~ts_ok | ana.battery_fault;
    assign start_ok = ana.conv_run & enable & (curr[F_FAST_CHARGE_CURRENT_SETTING+:6] != 6'h0)
                      & ts_ok & ~tfault & ~ctrl[B_BSWOFF];
    assign charging = (state == ST_SHORT) | (state == ST_PRE) | (state == ST_FAST);
    assign slow     = ctrl[B_SLOW] & (ana.loops | (ctrl[B_PROF] & ~ctrl[B_BYPASS]
                      & ((ts.cool & ctrl[F_COOL+:2] != SCALE_FULL)
                      | (ts.warm & ctrl[F_WARM+:2] != SCALE_FULL))));
    assign tick_ok  = sec_tick & ~susp;
    assign safe_lim = (state == ST_FAST) ? (ctrl[B_TSEL] ? LIM_SLOW : LIM_FAST) : LIM_PRE;
    assign expire   = charging & ctrl[B_TMR] & (safe_cnt >= safe_lim);
    assign term_hit = (state == ST_FAST) & ana.below_term & ana.above_rechg
                      & ~ana.loops & ctrl[B_TERM] & ~susp
                      & ~(ts.warm & ctrl[B_PROF] & ~ctrl[B_BYPASS]);
    assign boost_flt = boost_mode & ~ctrl[B_BYPASS] & ~ts.bst_ok;

    // ****************************************
    // charge state machine
    // ****************************************
    // drop to off on restart
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_OFF;
        end else if (!enable || !ana.conv_run || ctrl[B_BSWOFF]) begin
            state <= ST_OFF;
        end else begin
            case (state)
                ST_OFF: begin
                    if (start_ok) state <= phase_of(ana.bat_short, ana.bat_low);
                end
                ST_SHORT, ST_PRE, ST_FAST: begin
                    if (expire) state <= ST_FAULT;
                    else if (term_hit) state <= ST_DONE;
                    else state <= phase_of(ana.bat_short, ana.bat_low);
                end
                ST_DONE: begin
                    if (!ana.above_rechg && start_ok)
                        state <= phase_of(ana.bat_short, ana.bat_low);
                end
                ST_FAULT: state <= ST_FAULT;
                default:  state <= ST_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) tfault <= 1'b0;
        else if (expire) tfault <= 1'b1;
        else if (!enable || !ana.conv_run) tfault <= 1'b0;
    end

    // ****************************************
    // safety timer
    // ****************************************
    // reset outside a cycle, half rate
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            safe_cnt <= 17'h0;
            safe_ph  <= 1'b0;
        end else if (!charging || !enable) begin
            safe_cnt <= 17'h0;
            safe_ph  <= 1'b0;
        end else if (tick_ok) begin
            safe_ph <= ~safe_ph;
            if (!slow || safe_ph) safe_cnt <= safe_cnt + 17'h1;
        end
    end

    // ****************************************
    // top-off timer
    // ****************************************
    // sampled at termination, follows safety gating
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            topo_run <= 1'b0;
            topo_cnt <= 17'h0;
            topo_lim <= 17'h0;
            topo_ph  <= 1'b0;
        end else if (term_hit) begin
            topo_run <= ctrl[F_TOPO+:2] != 2'h0;
            topo_cnt <= 17'h0;
            topo_lim <= 17'(ctrl[F_TOPO+:2] * TOPO_STEP);
            topo_ph  <= 1'b0;
        end else if (state != ST_DONE || ctrl[F_TOPO+:2] == 2'h0) begin
            topo_run <= 1'b0;
        end else if (topo_run && topo_cnt >= topo_lim) begin
            topo_run <= 1'b0;
        end else if (topo_run && tick_ok) begin
            topo_ph <= ~topo_ph;
            if (!slow || topo_ph) topo_cnt <= topo_cnt + 17'h1;
        end
    end

    // ****************************************
    // host alert pulse
    // ****************************************
    // alert events
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alert_cnt <= 32'h0;
            alert_n   <= 1'b1;
        end else if (term_hit || expire || (topo_run && state == ST_DONE
                     && ctrl[F_TOPO+:2] != 2'h0 && topo_cnt >= topo_lim)) begin
            alert_cnt <= 32'(ALERT_CYCLES - 1);
            alert_n   <= 1'b0;
        end else if (alert_cnt != 32'h0) begin
            alert_cnt <= alert_cnt - 32'h1;
        end else begin
            alert_n <= 1'b1;
        end
    end

    // ****************************************
    // power stage controls
    // ****************************************
    // current, voltage, switch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            i_mode         <= 2'h0;
            i_scale        <= SCALE_FULL;
            v_warm_reduce  <= 1'b0;
            batt_switch_on <= 1'b1;
            boost_suspend  <= 1'b0;
        end else begin
            i_mode         <= (charging && !susp) ? 2'(state) : 2'h0;
            i_scale        <= (!ctrl[B_PROF] || ctrl[B_BYPASS]) ? SCALE_FULL :
                              ts.cool ? ctrl[F_COOL+:2] :
                              ts.warm ? ctrl[F_WARM+:2] : SCALE_FULL;
            v_warm_reduce  <= ctrl[B_PROF] & ~ctrl[B_BYPASS] & ts.warm & ctrl[B_WVSEL];
            batt_switch_on <= ~ctrl[B_BSWOFF] & (charging | ana.supplement
                              | (state == ST_OFF));
            boost_suspend  <= boost_flt;
        end
    end

    // setting mirrors for the analog side
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fast_charge_current_setting_code              <= CURR_RST[F_FAST_CHARGE_CURRENT_SETTING+:6];
            ipre_code              <= CURR_RST[F_IPRE+:4];
            iterm_code             <= CURR_RST[F_ITERM+:4];
            vreg_code              <= CURR_RST[F_VREG+:8];
            recharge_offset_select <= CTRL_RST[B_RECHG];
        end else begin
            fast_charge_current_setting_code              <= curr[F_FAST_CHARGE_CURRENT_SETTING+:6];
            ipre_code              <= curr[F_IPRE+:4];
            iterm_code             <= curr[F_ITERM+:4];
            vreg_code              <= curr[F_VREG+:8];
            recharge_offset_select <= ctrl[B_RECHG];
        end
    end

    // ****************************************
    // status pin
    // ****************************************
    // blink on fault, low while charging
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            blink   <= 1'b0;
            stat_oe <= 1'b0;
        end else begin
            if (half_tick) blink <= ~blink;
            if (state == ST_FAULT || (charging && susp)) stat_oe <= blink;
            else stat_oe <= charging;
        end
    end

    // ****************************************
    // status codes
    // ****************************************
    always_comb begin
        case (state)
            ST_SHORT, ST_PRE: phase_code = CS_PRE;
            ST_FAST:          phase_code = CS_FAST;
            ST_DONE:          phase_code = CS_DONE;
            default:          phase_code = CS_OFF;
        endcase
        if (ctrl[B_BYPASS]) ts_code = 3'h0;
        else if ((boost_mode ? ~ts.bst_ok : ts_out) && ts.cold) ts_code = TF_COLD;
        else if (boost_mode ? ~ts.bst_ok : ts_out) ts_code = TF_HOT;
        else ts_code = 3'h0;
    end

    // ****************************************
    // apb registers
    // ****************************************
    // defaults, one wait state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl    <= CTRL_RST;
            curr    <= CURR_RST;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= paddr != OFS_CTRL && paddr != OFS_CURR && paddr != OFS_STAT;
            prdata  <= 32'h0;
            if (!pwrite) begin
                case (paddr)
                    OFS_CTRL: prdata <= ctrl;
                    OFS_CURR: prdata <= curr;
                    OFS_STAT: prdata <= {20'h0,
                                         boost_mode ? (boost_flt ? 3'h0 : SRC_BST) : src_type,
                                         ts_code, tfault ? CF_TMR : 2'h0,
                                         1'b0, topo_run, phase_code};
                    default:  prdata <= 32'h0;
                endcase
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            // writes land at the completing edge
            if (psel && penable && pwrite && paddr == OFS_CTRL) ctrl <= {16'h0, pwdata[15:0]};
            if (psel && penable && pwrite && paddr == OFS_CURR) curr <= {8'h0, pwdata[23:0]};
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    cycle_start_a: assert property (
        $past(state) == ST_OFF && charging |-> $past(start_ok))
        else $error("cycle started without qualification");
    term_done_a: assert property (
        term_hit |=> state == ST_DONE || !enable || !ana.conv_run)
        else $error("termination did not reach done");
    restart_off_a: assert property (
        en_q && !enable |=> state == ST_OFF && safe_cnt == 17'h0)
        else $error("enable drop did not stop cycle");
    done_alert_a: assert property (
        term_hit |=> !alert_n [*8])
        else $error("no alert after completion");
    warm_noterm_a: assert property (
        ts.warm && ctrl[B_PROF] && !ctrl[B_BYPASS] && state == ST_FAST |=> state != ST_DONE)
        else $error("termination in warm zone");
    bypass_code_a: assert property (
        ctrl[B_BYPASS] && psel && penable && !pready && !pwrite && paddr == OFS_STAT
        |=> prdata[8:6] == 3'h0)
        else $error("thermistor code not cleared under bypass");
    topo_stop_a: assert property (
        topo_run && ctrl[F_TOPO+:2] == 2'h0 && !term_hit |=> !topo_run)
        else $error("top-off did not stop on disable");
    susp_freeze_a: assert property (
        charging && susp && $past(charging) |=> $stable(safe_cnt) || !charging)
        else $error("safety timer ran while suspended");
    expire_fault_a: assert property (
        expire |=> tfault ##1 state == ST_FAULT || !enable)
        else $error("expiry did not raise fault");
endmodule : ccc_ctrl

// >>> tb/ccc_host.sv
// ccc_host: host model, an apb master and the charge enable pin
// assumes the apb slave answers with pready sampled on a rising clk_sys edge
`timescale 1ns/1ps
module ccc_host (
    // clock
    input  wire logic        clk_sys,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    // enable pin, active low
    output logic             charge_enable_n
);
    // idle bus, charging pin released at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        charge_enable_n = 1'b1;
    end

    task pin(input logic v);
        @(posedge clk_sys);
        charge_enable_n <= v;
    endtask : pin

    // register access, request held until pready
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : ccc_host

// >>> tb/test_charge_cycle_controller.sv
// test_charge_cycle_controller: self-checking bench for ccc_ctrl
// assumes short tick and alert parameters; reads checked from a queue
`timescale 1ns/1ps
module test_charge_cycle_controller;
    import ccc_pkg::*;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, charge_enable_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    ccc_ana_s ana;
    ccc_ts_s ts;
    logic [2:0] src_type;
    logic boost_mode, stat_oe, alert_n;
    logic batt_switch_on, boost_suspend;
    logic [22:0] codes;
    logic [1:0] i_mode, i_scale;
    logic [32:0] exp_q[$], msk_q[$];
    int fail_count = 0, compares = 0, n;

    ccc_ctrl #(.ALERT_CYCLES(8), .HALF_CYCLES(2)) ccc_ctrl_inst (.clk_sys(clk_sys),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ana(ana),
        .ts(ts), .src_type(src_type), .boost_mode(boost_mode),
        .charge_enable_n(charge_enable_n), .i_mode(i_mode), .i_scale(i_scale),
        .v_warm_reduce(), .batt_switch_on(batt_switch_on), .boost_suspend(boost_suspend),
        .fast_charge_current_setting_code(codes[21:16]), .ipre_code(codes[15:12]), .iterm_code(codes[11:8]),
        .vreg_code(codes[7:0]), .recharge_offset_select(codes[22]),
        .stat_oe(stat_oe), .alert_n(alert_n));
    ccc_host ccc_host_inst (.clk_sys(clk_sys), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .charge_enable_n(charge_enable_n));

    // ****************************************
    // helpers
    // ****************************************
    function logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // note the expected word, then read it
    task rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        ccc_host_inst.xfer(1'b0, a, 32'h0);
    endtask : rd
    task wm(input logic [1:0] m);
        repeat (80) if (i_mode !== m) @(posedge clk_sys);
        chk("i_mode", 33'(m), 33'(i_mode));
    endtask : wm
    task end_sim;
        $display("counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // read results taken off the queue as they appear
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("prdata", exp_q.pop_front(), {pslverr, prdata} & msk_q.pop_front());
    end
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #300000;
        fail_count++;
        end_sim;
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        rst_n = 1'b0;
        ana = 8'h80;
        ts = 5'h01;
        boost_mode = 1'b0;
        rnd = xs(32'h224e);
        src_type = rnd[2:0];
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(OFS_CTRL, {1'b0, CTRL_RST}, 33'h0ffffffff);
        rd(OFS_CURR, {1'b0, CURR_RST}, 33'h0ffffffff);
        rd(8'h0c, 33'h100000000, 33'h1ffffffff);
        rd(OFS_STAT, 33'(CS_OFF), 33'h3);
        chk("codes", 33'({CTRL_RST[B_RECHG], CURR_RST[5:0], CURR_RST[11:8],
            CURR_RST[15:12], CURR_RST[23:16]}), 33'(codes));
        rnd = xs(rnd);
        ccc_host_inst.xfer(1'b1, OFS_CURR, rnd);
        rd(OFS_CURR, 33'(rnd), 33'h000ffffff);
        chk("codes", 33'({1'b0, rnd[5:0], rnd[11:8], rnd[15:12], rnd[23:16]}),
            33'(codes));
        ccc_host_inst.xfer(1'b1, OFS_CURR, CURR_RST);
        $display("test registers done");
        @(posedge clk_sys) {boost_mode, ts.bst_ok} <= 2'b10;
        rd(OFS_STAT, 33'(TF_HOT) << 6, 33'hfc0);
        chk("boost_suspend", 33'h1, 33'(boost_suspend));
        @(posedge clk_sys) {boost_mode, ts.bst_ok} <= 2'b01;
        rd(OFS_STAT, 33'(src_type) << 9, 33'hfc0);
        chk("boost_suspend", 33'h0, 33'(boost_suspend));
        $display("test boost done");
        ccc_host_inst.pin(1'b0);
        wm(2'h3);
        chk("stat_oe", 33'h1, 33'(stat_oe));
        rd(OFS_STAT, 33'(CS_FAST), 33'h3);
        @(posedge clk_sys) ts.cool <= 1'b1;
        repeat (80) if (i_scale !== 2'h1) @(posedge clk_sys);
        chk("i_scale", 33'h1, 33'(i_scale));
        @(posedge clk_sys) ts.cool <= 1'b0;
        $display("test fast charge done");
        @(posedge clk_sys) {ana.below_term, ana.above_rechg} <= 2'b11;
        repeat (80) if (alert_n !== 1'b0) @(posedge clk_sys);
        n = 0;
        while (alert_n === 1'b0 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        chk("alert_len", 33'd8, 33'(n));
        chk("stat_oe", 33'h0, 33'(stat_oe));
        chk("batt_switch_on", 33'h0, 33'(batt_switch_on));
        rd(OFS_STAT, 33'(CS_DONE), 33'h3);
        @(posedge clk_sys) {ana.below_term, ana.above_rechg} <= 2'b00;
        wm(2'h3);
        $display("test termination done");
        ccc_host_inst.pin(1'b1);
        wm(2'h0);
        rd(OFS_STAT, 33'(CS_OFF), 33'h3);
        @(posedge clk_sys) ana.bat_low <= 1'b1;
        ccc_host_inst.pin(1'b0);
        wm(2'h2);
        rd(OFS_STAT, 33'(CS_PRE), 33'h3);
        @(posedge clk_sys) ts.cold <= 1'b1;
        wm(2'h0);
        rd(OFS_STAT, 33'(TF_COLD) << 6, 33'h1c0);
        ccc_host_inst.xfer(1'b1, OFS_CTRL, CTRL_RST | 32'h4);
        wm(2'h2);
        rd(OFS_STAT, 33'h0, 33'h1c0);
        $display("test restart and thermistor done");
        repeat (40000) if (alert_n !== 1'b0) @(posedge clk_sys);
        chk("expire_alert", 33'h0, 33'(alert_n));
        rd(OFS_STAT, 33'(CF_TMR) << 4, 33'h33);
        wm(2'h0);
        n = stat_oe;
        repeat (2) @(posedge clk_sys);
        chk("stat_blink", 33'(n ^ 1), 33'(stat_oe));
        $display("test safety timer done");
        repeat (4) @(posedge clk_sys);
        end_sim;
    end
endmodule : test_charge_cycle_controller
